// ===== core/pbg_pkg.sv
// Constants, register map and field layout of the port B GPIO block
// Behaviour
// R01: Eight independent bidirectional pins, each with own latch bit and direction bit.
// R02: Direction one floats the driver; direction zero drives the latch value.
// R03: Port read returns pin levels; port write only updates the output latch.
// R04: Each port write is read pins, modify, store result into the latch.
// R05: Option bit 7, active low, enables weak pull-ups on all pins together.
// R06: A pin configured as output never has its pull-up enabled. Code drops the pull-up one enabled clock after the direction write.
// R07: Pull-ups are disabled after power-on reset.
// R08: Only pins 4 to 7 configured as inputs take part in change detection.
// R09: Input pins compared with last-read snapshot; mismatches ORed into change flag bit 0.
// R10: Mismatch keeps setting flag; any port access refreshes snapshot, then flag clears. Code keeps flag until software writes it.
// R11: A set and enabled change interrupt wakes the device from halt.
// R12: A pin change in the same cycle as a port read may be missed.
// R13: Pin 0 is the external interrupt input, Schmitt buffer when used so.
// R14: Pins 6 and 7 use Schmitt buffers in serial programming mode.
// R15: Bit read-modify-write copies input pin levels into their latch bits.
// R16: Port writes take effect at cycle end; reads sample at cycle start.
// R17: Core leaves one unrelated instruction between port write and following read.
// R18: Core avoids polling the port while change detection is in use.
// R19: Change request is flag AND enable; flag setting ignores the enable.
package pbg_pkg;
    localparam int PBG_WIDTH = 8;
    localparam int PBG_ADDR_W = 8;
    // Register offsets
    localparam logic [7:0] PBG_ADDR_PORT = 8'h06;
    localparam logic [7:0] PBG_ADDR_OPTION = 8'h81;
    localparam logic [7:0] PBG_ADDR_DIR = 8'h86;
    localparam logic [7:0] PBG_ADDR_INTCTL = 8'h0B;
    localparam logic [7:0] PBG_ADDR_IRQ_STAT = 8'hF0;
    localparam logic [7:0] PBG_ADDR_IRQ_MASK = 8'hF1;
    // Reset values
    localparam logic [7:0] PBG_OPTION_RST = 8'hFF;
    localparam logic [7:0] PBG_DIR_RST = 8'hFF;
    localparam logic [7:0] PBG_INTCTL_RST = 8'h00;
    localparam logic [7:0] PBG_LATCH_RST = 8'h00;
    localparam logic [7:0] PBG_ZERO = 8'h00;
    // Option register fields
    localparam int PBG_OPT_PULLUP_N = 7;
    localparam int PBG_OPT_EDGE = 6;
    // Interrupt control register fields
    localparam int PBG_ICR_CHG_FLAG = 0;
    localparam int PBG_ICR_EXT_FLAG = 1;
    localparam int PBG_ICR_CHG_EN = 3;
    localparam int PBG_ICR_EXT_EN = 4;
    // Interrupt status and mask fields
    localparam int PBG_IRQ_CHG = 0;
    localparam int PBG_IRQ_EXT = 1;
    localparam int PBG_IRQ_W = 2;
    // Pin roles
    localparam logic [7:0] PBG_CHG_MASK = 8'hF0;
    localparam int PBG_EXT_PIN = 0;
    localparam int PBG_PROG_CLK = 6;
    localparam int PBG_PROG_DAT = 7;
endpackage

// ===== core/pbg_port.sv
// Port B GPIO block with pull-ups, change detection and interrupts
`timescale 1ns/1ps
module pbg_port
    import pbg_pkg::*;
#(
    parameter int WIDTH = PBG_WIDTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [PBG_ADDR_W-1:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WIDTH-1:0] reg_rdata,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic halted,
    input wire logic prog_mode,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n,
    output logic [WIDTH-1:0] pullup_en,
    output logic [WIDTH-1:0] schmitt_sel,
    output logic change_irq,
    output logic wake,
    output logic irq
);

    // Address compare shared by every decode
    function automatic logic reg_hit(input logic [PBG_ADDR_W-1:0] a,
                                     input logic [PBG_ADDR_W-1:0] off);
        reg_hit = (a == off);
    endfunction

    logic [WIDTH-1:0] pin_meta_q;
    logic [WIDTH-1:0] pin_sync_q;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] option_q;
    logic [WIDTH-1:0] intctl_q;
    logic [WIDTH-1:0] snap_q;
    logic [WIDTH-1:0] rdata_q;
    logic [WIDTH-1:0] pullup_q;
    logic [WIDTH-1:0] schmitt_q;
    logic [WIDTH-1:0] rmw_value;
    logic [WIDTH-1:0] rd_value;
    logic [PBG_IRQ_W-1:0] stat_q;
    logic [PBG_IRQ_W-1:0] mask_q;
    logic ext_prev_q;
    logic change_irq_q;
    logic wake_q;
    logic irq_q;
    logic wr_port;
    logic rd_port;
    logic wr_dir;
    logic wr_option;
    logic wr_intctl;
    logic wr_mask;
    logic rd_stat;
    logic port_access;
    logic mismatch;
    logic change_set;
    logic ext_set;

    // Strobe decode
    always_comb begin
        wr_port = reg_wr && reg_hit(reg_addr, PBG_ADDR_PORT);
        rd_port = reg_rd && reg_hit(reg_addr, PBG_ADDR_PORT);
        wr_dir = reg_wr && reg_hit(reg_addr, PBG_ADDR_DIR);
        wr_option = reg_wr && reg_hit(reg_addr, PBG_ADDR_OPTION);
        wr_intctl = reg_wr && reg_hit(reg_addr, PBG_ADDR_INTCTL);
        wr_mask = reg_wr && reg_hit(reg_addr, PBG_ADDR_IRQ_MASK);
        rd_stat = reg_rd && reg_hit(reg_addr, PBG_ADDR_IRQ_STAT);
        port_access = wr_port || rd_port || bit_wr;
    end

    // Two-stage pin synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= PBG_ZERO;
            pin_sync_q <= PBG_ZERO;
        end else if (ce) begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Bit operation on the pin levels, not the latch
    always_comb begin
        rmw_value = pin_sync_q; // R15
        rmw_value[bit_sel] = bit_val; // R04
    end

    // Output latch, one bit per pin, loaded at cycle end
    always_ff @(posedge clk) begin
        if (reset) begin
            latch_q <= PBG_LATCH_RST;
        end else if (ce) begin
            if (wr_port) begin
                latch_q <= reg_wdata; // R03 R16
            end else if (bit_wr) begin
                latch_q <= rmw_value; // R04 R15
            end
        end
    end

    // Direction register
    always_ff @(posedge clk) begin
        if (reset) begin
            dir_q <= PBG_DIR_RST;
        end else if (ce && wr_dir) begin
            dir_q <= reg_wdata; // R01
        end
    end

    // Option register, pull-up control in its top bit
    always_ff @(posedge clk) begin
        if (reset) begin
            option_q <= PBG_OPTION_RST; // R07
        end else if (ce && wr_option) begin
            option_q <= reg_wdata;
        end
    end

    // Change comparison against the snapshot
    always_comb begin
        mismatch = |((pin_sync_q ^ snap_q) & PBG_CHG_MASK & dir_q); // R08 R09
        change_set = mismatch && !port_access; // R10 R12
        ext_set = (pin_sync_q[PBG_EXT_PIN] != ext_prev_q) &&
                  (pin_sync_q[PBG_EXT_PIN] == option_q[PBG_OPT_EDGE]); // R13
    end

    // Snapshot refreshed by any port access
    always_ff @(posedge clk) begin
        if (reset) begin
            snap_q <= PBG_ZERO;
        end else if (ce && port_access) begin
            snap_q <= pin_sync_q & PBG_CHG_MASK; // R10
        end
    end

    // Previous level of the external interrupt pin
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_prev_q <= 1'b0;
        end else if (ce) begin
            ext_prev_q <= pin_sync_q[PBG_EXT_PIN];
        end
    end

    // Interrupt control register, hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (reset) begin
            intctl_q <= PBG_INTCTL_RST;
        end else if (ce) begin
            if (wr_intctl) begin
                intctl_q <= reg_wdata;
            end
            if (change_set) begin
                intctl_q[PBG_ICR_CHG_FLAG] <= 1'b1; // R09 R10 R19
            end
            if (ext_set) begin
                intctl_q[PBG_ICR_EXT_FLAG] <= 1'b1; // R13
            end
        end
    end

    // Sticky status, cleared by reading it
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_q <= '0;
        end else if (ce) begin
            if (rd_stat) begin
                stat_q <= '0;
            end
            if (change_set) begin
                stat_q[PBG_IRQ_CHG] <= 1'b1;
            end
            if (ext_set) begin
                stat_q[PBG_IRQ_EXT] <= 1'b1;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= '0;
        end else if (ce && wr_mask) begin
            mask_q <= reg_wdata[PBG_IRQ_W-1:0];
        end
    end

    // Interrupt, change request and wake outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
            change_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(stat_q & mask_q);
            change_irq_q <= intctl_q[PBG_ICR_CHG_FLAG] && intctl_q[PBG_ICR_CHG_EN]; // R19
            wake_q <= halted && intctl_q[PBG_ICR_CHG_FLAG] &&
                      intctl_q[PBG_ICR_CHG_EN]; // R11
        end
    end

    // Read mux, pins sampled at cycle start
    always_comb begin
        rd_value = PBG_ZERO;
        if (reg_hit(reg_addr, PBG_ADDR_PORT)) begin
            rd_value = pin_sync_q; // R03 R16
        end else if (reg_hit(reg_addr, PBG_ADDR_DIR)) begin
            rd_value = dir_q;
        end else if (reg_hit(reg_addr, PBG_ADDR_OPTION)) begin
            rd_value = option_q;
        end else if (reg_hit(reg_addr, PBG_ADDR_INTCTL)) begin
            rd_value = intctl_q;
        end else if (reg_hit(reg_addr, PBG_ADDR_IRQ_STAT)) begin
            rd_value = {{(WIDTH-PBG_IRQ_W){1'b0}}, stat_q};
        end else if (reg_hit(reg_addr, PBG_ADDR_IRQ_MASK)) begin
            rd_value = {{(WIDTH-PBG_IRQ_W){1'b0}}, mask_q};
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= PBG_ZERO;
        end else if (ce) begin
            rdata_q <= reg_rd ? rd_value : PBG_ZERO;
        end
    end

    // Per-pin pull-up and input buffer selection
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            always_ff @(posedge clk) begin
                if (reset) begin
                    pullup_q[gi] <= 1'b0; // R07
                    schmitt_q[gi] <= 1'b0;
                end else if (ce) begin
                    pullup_q[gi] <= !option_q[PBG_OPT_PULLUP_N] && dir_q[gi]; // R05 R06
                    if (gi == PBG_EXT_PIN) begin
                        schmitt_q[gi] <= intctl_q[PBG_ICR_EXT_EN]; // R13
                    end else if (gi == PBG_PROG_CLK || gi == PBG_PROG_DAT) begin
                        schmitt_q[gi] <= prog_mode; // R14
                    end else begin
                        schmitt_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Pin drive: enable low while the latch drives the pin
    assign pin_out = latch_q; // R02
    assign pin_oe_n = dir_q; // R02
    assign pullup_en = pullup_q;
    assign schmitt_sel = schmitt_q;
    assign reg_rdata = rdata_q;
    assign change_irq = change_irq_q;
    assign wake = wake_q;
    assign irq = irq_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_port_read;
        ce && rd_port;
    endsequence

    sequence s_port_write;
        ce && wr_port;
    endsequence

    chk_read_pins: assert property (s_port_read |=> reg_rdata == $past(pin_sync_q)) // R03
        else $error("port read did not return pin levels");

    chk_write_latch: assert property (s_port_write |=> pin_out == $past(reg_wdata)) // R04
        else $error("port write did not reach latch");

    chk_bit_rmw: assert property (ce && bit_wr && !wr_port |=> pin_out == $past(rmw_value)) // R15
        else $error("bit operation did not store pin based value");

    chk_dir_drive: assert property (ce && wr_dir |=> pin_oe_n == $past(reg_wdata)) // R02
        else $error("direction write not seen on enables");

    chk_pullup_out: assert property (ce |=> (pullup_en & ~$past(dir_q)) == PBG_ZERO) // R06
        else $error("pull-up on an output pin");

    chk_pullup_off: assert property (ce && option_q[PBG_OPT_PULLUP_N] |=> pullup_en == PBG_ZERO) // R05
        else $error("pull-ups on while disabled");

    chk_flag_set: assert property (ce && change_set |=> intctl_q[PBG_ICR_CHG_FLAG]) // R09
        else $error("change flag not set on mismatch");

    chk_flag_quiet: assert property (ce && !intctl_q[PBG_ICR_CHG_FLAG] && !wr_intctl && // R08
        ((pin_sync_q ^ snap_q) & PBG_CHG_MASK & dir_q) == PBG_ZERO
        |=> !intctl_q[PBG_ICR_CHG_FLAG])
        else $error("change flag set without input mismatch");

    chk_snap_refresh: assert property (ce && port_access |=> snap_q == // R10
        ($past(pin_sync_q) & PBG_CHG_MASK) ##0 (!mismatch || $changed(pin_sync_q)))
        else $error("snapshot not refreshed by port access");

    chk_req_gated: assert property (ce && !intctl_q[PBG_ICR_CHG_EN] |=> !change_irq) // R19
        else $error("change request without enable");

    chk_wake_req: assert property (ce && halted && intctl_q[PBG_ICR_CHG_FLAG] && // R11
        intctl_q[PBG_ICR_CHG_EN] |=> wake)
        else $error("no wake from halt on change");

    chk_prog_schmitt: assert property (ce && prog_mode |=> // R14
        schmitt_sel[PBG_PROG_CLK] && schmitt_sel[PBG_PROG_DAT])
        else $error("programming pins not on Schmitt buffer");

    // Interrupt bookkeeping, built from the event steps
    sequence s_change_seen;
        ce && change_set;
    endsequence

    sequence s_ext_seen;
        ce && ext_set;
    endsequence

    sequence s_stat_read;
        ce && rd_stat && !change_set && !ext_set;
    endsequence

    chk_stat_change: assert property (s_change_seen |=> stat_q[PBG_IRQ_CHG]) // R09
        else $error("status bit not set on change");

    chk_ext_flag: assert property (s_ext_seen |=> // R13
        intctl_q[PBG_ICR_EXT_FLAG] && stat_q[PBG_IRQ_EXT])
        else $error("edge on interrupt pin not latched");

    chk_stat_clear: assert property (s_stat_read |=> stat_q == '0)
        else $error("status not cleared by its read");

    chk_flag_hold: assert property (ce && intctl_q[PBG_ICR_CHG_FLAG] && !wr_intctl |=> // R09
        intctl_q[PBG_ICR_CHG_FLAG])
        else $error("change flag lost without software clear");

    chk_ext_schmitt: assert property (ce |=> // R13
        schmitt_sel[PBG_EXT_PIN] == $past(intctl_q[PBG_ICR_EXT_EN]))
        else $error("interrupt pin buffer not following its enable");

    chk_pullup_on: assert property (ce && !option_q[PBG_OPT_PULLUP_N] |=> // R05
        pullup_en == $past(dir_q))
        else $error("pull-ups not on for every input");

    chk_pullup_reset: assert property (@(posedge clk) disable iff (1'b0) reset |=> // R07
        pullup_en == PBG_ZERO)
        else $error("pull-ups on after reset");

    chk_latch_hold: assert property (ce && !wr_port && !bit_wr |=> $stable(pin_out)) // R03
        else $error("latch changed without a port write");

    chk_oe_hold: assert property (ce && !wr_dir |=> $stable(pin_oe_n)) // R02
        else $error("direction changed without a write");

    chk_req_on: assert property (ce && intctl_q[PBG_ICR_CHG_FLAG] && // R19
        intctl_q[PBG_ICR_CHG_EN] |=> change_irq)
        else $error("enabled change flag gave no request");

    chk_wake_quiet: assert property (ce && !halted |=> !wake) // R11
        else $error("wake raised while running");

    chk_irq_raise: assert property (ce && (stat_q & mask_q) != '0 |=> irq)
        else $error("unmasked status gave no interrupt");

    chk_irq_quiet: assert property (ce && (stat_q & mask_q) == '0 |=> !irq)
        else $error("interrupt without unmasked status");

    chk_ce_freeze: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe_n) &&
        $stable(pullup_en) && $stable(intctl_q))
        else $error("state moved while clock enable low");

endmodule

// ===== tb/bidir_port_with_change_irq_bench.sv
// Self-checking bench of the port B block
`timescale 1ns/1ps
module bidir_port_with_change_irq_bench;
    import pbg_pkg::*;
    logic clk, reset, reg_wr, reg_rd, bit_wr, bit_val, halted, prog_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_lvl, pin_out, pin_oe_n;
    logic [7:0] pullup_en, schmitt_sel, ext_en, ext_val, d, w, e, v, lat;
    logic [2:0] bit_sel;
    logic change_irq, wake, irq, ce;
    int err_count = 0;
    int n_checks = 0;
    int seed = 32'h9053;
    pbg_port u_pbg_port (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .halted(halted),
        .prog_mode(prog_mode), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .schmitt_sel(schmitt_sel), .change_irq(change_irq),
        .wake(wake), .irq(irq));
    pbg_pins u_pbg_pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
    // Pin level seen with every input driven from outside
    function automatic logic [7:0] exp_pins(logic [7:0] dir, logic [7:0] lt, logic [7:0] ex);
        return (lt & ~dir) | (ex & dir);
    endfunction
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 dat = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        rd(a, got);
        chk(got, exp);
    endtask
    // Outside drive, then time for the two-stage synchroniser
    task automatic pins(input logic [7:0] en, input logic [7:0] val);
        @(posedge clk);
        ext_en <= en;
        ext_val <= val;
        repeat (3) @(posedge clk);
    endtask
    task automatic bitop(input int i, input logic b);
        @(posedge clk);
        bit_wr <= 1'b1;
        bit_sel <= 3'(i);
        bit_val <= b;
        @(posedge clk);
        bit_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        {reset, reg_wr, reg_rd, bit_wr, bit_val, halted, prog_mode} = 7'h01 << 6;
        {reg_addr, reg_wdata, bit_sel, ext_val} = '0;
        ext_en = 8'hFF;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1 chk(pullup_en, 8'h00);
        chk(pin_oe_n, 8'hFF);
        rdc(PBG_ADDR_OPTION, 8'hFF);
        rdc(PBG_ADDR_DIR, 8'hFF);
        rdc(PBG_ADDR_INTCTL, 8'h00);
        rdc(8'h33, 8'h00);
        $display("reset values done");
        // Random directions, latch values and outside levels
        for (int k = 0; k < 12; k++) begin
            d = $random(seed);
            w = $random(seed);
            e = $random(seed);
            pins(8'hFF, e);
            wr(PBG_ADDR_DIR, d);
            wr(PBG_ADDR_PORT, w);
            #1 chk(pin_out, w);
            chk(pin_oe_n, d);
            repeat (3) @(posedge clk);
            rdc(PBG_ADDR_PORT, exp_pins(d, w, e));
        end
        $display("direction and latch done");
        wr(PBG_ADDR_DIR, 8'hF0);
        pins(8'h00, 8'h00);
        wr(PBG_ADDR_OPTION, 8'h7F);
        repeat (2) @(posedge clk);
        #1 chk(pullup_en, 8'hF0);
        rdc(PBG_ADDR_PORT, {4'hF, w[3:0]});
        wr(PBG_ADDR_OPTION, 8'hFF);
        repeat (2) @(posedge clk);
        #1 chk(pullup_en, 8'h00);
        $display("pull-ups done");
        pins(8'hFF, 8'hA0);
        wr(PBG_ADDR_PORT, 8'h05);
        lat = 8'h05;
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            bitop(i, v[0]);
            lat = {4'hA, lat[3:0]};
            lat[i] = v[0];
            chk(pin_out, lat);
        end
        $display("bit operations done");
        // Change detection on the upper inputs only
        wr(PBG_ADDR_DIR, 8'hFF);
        rd(PBG_ADDR_PORT, v);
        rd(PBG_ADDR_IRQ_STAT, v);
        wr(PBG_ADDR_INTCTL, 8'h08);
        halted <= 1'b1;
        pins(8'hFF, 8'hB0);
        for (int k = 0; k < 10 && change_irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (change_irq !== 1'b1) begin
            err_count++;
            conclude();
        end
        repeat (2) @(posedge clk);
        #1 chk(wake, 1'b1);
        rdc(PBG_ADDR_INTCTL, 8'h09);
        wr(PBG_ADDR_INTCTL, 8'h08);
        rdc(PBG_ADDR_INTCTL, 8'h09);
        rd(PBG_ADDR_PORT, v);
        wr(PBG_ADDR_INTCTL, 8'h08);
        rdc(PBG_ADDR_INTCTL, 8'h08);
        #1 chk(change_irq, 1'b0);
        chk(wake, 1'b0);
        pins(8'hFF, 8'hB4);
        repeat (3) @(posedge clk);
        rdc(PBG_ADDR_INTCTL, 8'h08);
        wr(PBG_ADDR_PORT, 8'h00);
        wr(PBG_ADDR_DIR, 8'h7F);
        repeat (5) @(posedge clk);
        rdc(PBG_ADDR_INTCTL, 8'h08);
        rd(PBG_ADDR_IRQ_STAT, v);
        wr(PBG_ADDR_INTCTL, 8'h00);
        pins(8'hFF, 8'h94);
        repeat (3) @(posedge clk);
        rdc(PBG_ADDR_INTCTL, 8'h01);
        #1 chk(change_irq, 1'b0);
        $display("change detection done");
        // Status, mask and the level interrupt
        wr(PBG_ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1);
        rd(PBG_ADDR_PORT, v);
        rdc(PBG_ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0);
        wr(PBG_ADDR_IRQ_MASK, 8'h00);
        pins(8'hFF, 8'hD4);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b0);
        rd(PBG_ADDR_PORT, v);
        rdc(PBG_ADDR_IRQ_STAT, 8'h01);
        rdc(PBG_ADDR_IRQ_STAT, 8'h00);
        // Rising edge on the interrupt pin, its status bit unmasked
        wr(PBG_ADDR_IRQ_MASK, 8'h02);
        pins(8'hFF, 8'hD5);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1);
        rdc(PBG_ADDR_INTCTL, 8'h03);
        rdc(PBG_ADDR_IRQ_STAT, 8'h02);
        pins(8'hFF, 8'hD4);
        rdc(PBG_ADDR_IRQ_STAT, 8'h00);
        wr(PBG_ADDR_IRQ_MASK, 8'h00);
        $display("interrupt status done");
        prog_mode <= 1'b1;
        wr(PBG_ADDR_INTCTL, 8'h10);
        repeat (2) @(posedge clk);
        #1 chk(schmitt_sel, 8'hC1);
        @(posedge clk);
        prog_mode <= 1'b0;
        wr(PBG_ADDR_INTCTL, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(schmitt_sel, 8'h00);
        $display("input buffers done");
        // Clock enable low: a port write is ignored
        wr(PBG_ADDR_PORT, 8'h00);
        ce <= 1'b0;
        wr(PBG_ADDR_PORT, 8'h3C);
        @(posedge clk);
        ce <= 1'b1;
        #1 chk(pin_out, 8'h00);
        $display("clock enable done");
        // Second reset with pull-ups on every input
        wr(PBG_ADDR_OPTION, 8'h7F);
        repeat (2) @(posedge clk);
        #1 chk(pullup_en, 8'h7F);
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1 chk(pullup_en, 8'h00);
        rdc(PBG_ADDR_OPTION, 8'hFF);
        rdc(PBG_ADDR_DIR, 8'hFF);
        $display("second reset done");
        conclude();
    end
endmodule

// ===== tb/pbg_pins.sv
// External pin model: outside drivers, pull-ups, floating lines
`timescale 1ns/1ps
module pbg_pins (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_lvl
);
    logic [7:0] wobble_q = 8'h55;
    // Undriven lines flip every cycle, never a steady value
    always @(posedge clk) begin
        wobble_q <= ~wobble_q;
    end
    // Device driver wins, then outside driver, then weak pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
            else if (ext_en[i]) pin_lvl[i] = ext_val[i];
            else if (pullup_en[i]) pin_lvl[i] = 1'b1;
            else pin_lvl[i] = wobble_q[i];
        end
    end
endmodule
